// ### hdl/dlc_regs.sv
/*
 * deserializer link configuration register group with master clock
 * generator and slave data-setup hold-off.
 * assumes: register port from local control logic on core_clk; remote
 * config arrives as a one-cycle load pulse on core_clk; the i2c clock
 * pin level arrives asynchronously.
 */
`timescale 1ns/10ps
module dlc_regs (
    // clock, reset, enable
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // register port
    input  wire dlc_pkg::dlc_req_s req,
    output dlc_pkg::dlc_rsp_s     rsp,
    // forward-channel config load
    input  wire dlc_pkg::dlc_fc_s fc,
    // self-test
    input  wire logic             selftest_en,
    input  wire logic             selftest_err,
    // receive lock
    input  wire logic             rx_lock_mode,
    input  wire logic             link_up,
    output logic                  rx_lock,
    // local bus master clock
    input  wire logic             master_go,
    input  wire logic             master_stop,
    input  wire logic             scl_in,
    output logic                  scl_out,
    output logic                  scl_oe,
    // slave clock stretch
    input  wire logic             slave_data_set,
    output logic                  slave_release,
    // datapath controls
    output logic                  video_disabled,
    output logic                  dual_link,
    output logic                  ctrl_chan_en,
    output logic                  audio_on_pins,
    output logic                  audio_en,
    output logic                  sync_bits_in_stream,
    output logic                  surround_en
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]      tally;   // self-test error tally
        logic [7:0]      high_w;  // master clock high width
        logic [7:0]      low_w;   // master clock low width
        logic [7:0]      dpcfg;   // datapath config
        dlc_pkg::dlc_rsp_s rsp;
        dlc_pkg::dlc_clk_e cst;   // master clock phase
        logic [2:0]      scl_sy;  // pin synchroniser, three stages
        logic            scl_lvl; // agreed pin level
        logic            slv_wait;// slave setup window running
        logic            slv_rel;
        logic            scl_oe;
        logic            rx_lock;
        logic [6:0]      outs;    // registered decoded controls
    } dlc_st_s;
    dlc_st_s st_r, st_nxt;
    logic    tmr_start;  // start a phase or setup window
    logic [7:0] tmr_w;   // width for the timer
    logic    tmr_done;   // phase over
    // shared timer: master and slave never run together
    dlc_phase_timer #(.UNIT(dlc_pkg::UNIT_CYC)) u_tmr (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .start    (tmr_start),
        .width    (tmr_w),
        .done     (tmr_done)
    );
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // priorities inside one cycle: a local write lands first, a remote
    // load then replaces bits 5..0 unless the freeze bit (after the
    // write) is set; reads see the registered state, so a read and a
    // write to one offset in one cycle return the old value
    always_comb begin
        logic [7:0] keep;
        keep      = 8'h00;
        st_nxt    = st_r;
        tmr_start = 1'b0;
        tmr_w     = st_r.high_w;
        st_nxt.rsp.rvalid = 1'b0;
        // pin sync: change counted when stages two and three agree
        st_nxt.scl_sy = {st_r.scl_sy[1:0], scl_in};
        if (st_r.scl_sy[2] == st_r.scl_sy[1]) begin
            st_nxt.scl_lvl = st_r.scl_sy[2];
        end
        // tally counts only with self-test on, saturating
        if (selftest_en && selftest_err && st_r.tally != dlc_pkg::TALLY_MAX)
        begin
            st_nxt.tally = st_r.tally + 8'h01;
        end
        // register writes; tally write ignored
        if (req.wr) begin
            case (req.addr)
                dlc_pkg::ADR_HIGH:  st_nxt.high_w = req.wdata;
                dlc_pkg::ADR_LOW:   st_nxt.low_w  = req.wdata;
                dlc_pkg::ADR_DPCFG: st_nxt.dpcfg  = req.wdata;
                default: ;          // tally and unmapped: no effect
            endcase
        end
        // remote load after local write so it wins unless frozen
        if (fc.load && !st_nxt.dpcfg[dlc_pkg::BIT_FREEZE]) begin
            keep = st_nxt.dpcfg & ~dlc_pkg::REMOTE_MASK;
            st_nxt.dpcfg = keep | ({2'b00, fc.cfg} & dlc_pkg::REMOTE_MASK);
        end
        // register reads, answer one cycle later
        if (req.rd) begin
            st_nxt.rsp.rvalid = 1'b1;
            case (req.addr)
                dlc_pkg::ADR_TALLY: st_nxt.rsp.rdata = st_r.tally;
                dlc_pkg::ADR_HIGH:  st_nxt.rsp.rdata = st_r.high_w;
                dlc_pkg::ADR_LOW:   st_nxt.rsp.rdata = st_r.low_w;
                dlc_pkg::ADR_DPCFG: st_nxt.rsp.rdata = st_r.dpcfg;
                default:            st_nxt.rsp.rdata = 8'h00;
            endcase
        end
        // master clock: drive low means oe high
        case (st_r.cst)
            dlc_pkg::ST_IDLE: begin
                st_nxt.scl_oe = 1'b0;
                if (master_go) begin
                    st_nxt.cst = dlc_pkg::ST_HIGH;
                    tmr_start  = 1'b1;
                    tmr_w      = st_r.high_w;
                end else if (slave_data_set && !st_r.slv_wait) begin
                    // data placed; hold clock low for setup time
                    st_nxt.slv_wait = 1'b1;
                    st_nxt.slv_rel  = 1'b0;
                    tmr_start       = 1'b1;
                    tmr_w           = st_r.low_w;
                end else if (st_r.slv_wait && tmr_done) begin
                    st_nxt.slv_wait = 1'b0;
                    st_nxt.slv_rel  = 1'b1;
                end else begin
                    st_nxt.slv_rel  = 1'b0;
                end
            end
            dlc_pkg::ST_HIGH: begin
                st_nxt.scl_oe = 1'b0;
                // high phase counted only once pin really high
                if (!st_r.scl_lvl) begin
                    tmr_start = 1'b1;
                    tmr_w     = st_r.high_w;
                end else if (tmr_done) begin
                    st_nxt.cst    = dlc_pkg::ST_LOW;
                    st_nxt.scl_oe = 1'b1;
                    tmr_start     = 1'b1;
                    tmr_w         = st_r.low_w;
                end
            end
            dlc_pkg::ST_LOW: begin
                // stop is looked at only as a low phase ends, so the
                // clock line is always left released
                st_nxt.scl_oe = 1'b1;
                if (tmr_done) begin
                    st_nxt.scl_oe = 1'b0;
                    st_nxt.cst    = master_stop ? dlc_pkg::ST_IDLE
                                                : dlc_pkg::ST_HIGH;
                    tmr_start     = !master_stop;
                    tmr_w         = st_r.high_w;
                end
            end
            default: st_nxt.cst = dlc_pkg::ST_IDLE;
        endcase
        // lock: mode 0 needs active video; it reads the register, not
        // the decoded flag, and follows a remote load in the same cycle as that flag
        st_nxt.rx_lock = link_up &&
            (rx_lock_mode || !st_r.dpcfg[dlc_pkg::BIT_NOVID]);
        // decoded controls trail the register by one cycle; kept in
        // flops so that every output leaves a register
        st_nxt.outs[6] = st_r.dpcfg[dlc_pkg::BIT_NOVID];
        st_nxt.outs[5] = st_r.dpcfg[dlc_pkg::BIT_DUAL];
        st_nxt.outs[4] = 1'b1; // control channel never gated by video
        st_nxt.outs[3] = st_r.dpcfg[dlc_pkg::BIT_ALTAUD];
        st_nxt.outs[2] = !st_r.dpcfg[dlc_pkg::BIT_AUDOFF];
        st_nxt.outs[1] = st_r.dpcfg[dlc_pkg::BIT_SYNC];
        st_nxt.outs[0] = st_r.dpcfg[dlc_pkg::BIT_SURR] &&
                         !st_r.dpcfg[dlc_pkg::BIT_AUDOFF];
    end
    // ------------------------------------------------------------
    // register stage, frozen while ce low
    // ------------------------------------------------------------
    // synchroniser and agreed level start high, the pulled-up idle
    // level of the clock line, so no false edge follows reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r        <= '0;
            st_r.tally  <= dlc_pkg::RST_TALLY;
            st_r.high_w <= dlc_pkg::RST_HIGH;
            st_r.low_w  <= dlc_pkg::RST_LOW;
            st_r.dpcfg  <= dlc_pkg::RST_DPCFG;
            st_r.cst    <= dlc_pkg::ST_IDLE;
            st_r.scl_lvl <= 1'b1;
            st_r.scl_sy <= 3'h7;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end
    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign rsp                 = st_r.rsp;
    assign rx_lock             = st_r.rx_lock;
    assign scl_out             = 1'b0 & st_r.scl_oe; // open drain: low only
    // open drain: the data level is tied low, only the enable moves
    assign scl_oe              = st_r.scl_oe;
    assign slave_release       = st_r.slv_rel;
    assign video_disabled      = st_r.outs[6];
    assign dual_link           = st_r.outs[5];
    assign ctrl_chan_en        = st_r.outs[4];
    assign audio_on_pins       = st_r.outs[3];
    assign audio_en            = st_r.outs[2];
    assign sync_bits_in_stream = st_r.outs[1];
    assign surround_en         = st_r.outs[0];
endmodule : dlc_regs

// ### hdl/dlc_pkg.sv
/*
 * constants, field layouts and carrier structs for the deserializer link
 * configuration and clock-timing register group.
 * assumes: one 200 mhz core clock; registers reached by an 8-bit
 * address/data register port from the device's own control logic.
 */
package dlc_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_TALLY  = 8'h25; // self-test error tally
    localparam logic [7:0] ADR_HIGH   = 8'h26; // master clock high width
    localparam logic [7:0] ADR_LOW    = 8'h27; // master clock low width
    localparam logic [7:0] ADR_DPCFG  = 8'h28; // link datapath config
    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TALLY  = 8'h00;
    localparam logic [7:0] RST_HIGH   = 8'h83;
    localparam logic [7:0] RST_LOW    = 8'h84;
    localparam logic [7:0] RST_DPCFG  = 8'h00; // until first remote load
    localparam int BIT_FREEZE  = 7;   // freeze_remote_loading
    localparam int BIT_NOVID   = 5;   // video disabled
    localparam int BIT_DUAL    = 4;   // dual link
    localparam int BIT_ALTAUD  = 3;   // alternate audio on general pins
    localparam int BIT_AUDOFF  = 2;   // audio output disabled
    localparam int BIT_SYNC    = 1;   // sync_bits_in_stream
    localparam int BIT_SURR    = 0;   // surround audio
    localparam logic [7:0] REMOTE_MASK = 8'h3F; // bits remote may load
    localparam logic [7:0] TALLY_MAX   = 8'hFF; // tally saturates here
    // ------------------------------------------------------------
    // timing: one width unit is 50 ns
    // ------------------------------------------------------------
    localparam int UNIT_NS     = 50;
    localparam int CLK_PER_NS  = 5;
    localparam int UNIT_CYC    = UNIT_NS / CLK_PER_NS; // 10 cycles
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;    // write strobe
        logic       rd;    // read strobe
        logic [7:0] addr;  // register offset
        logic [7:0] wdata; // write data
    } dlc_req_s;
    typedef struct packed {
        logic       rvalid; // read answer valid, one cycle
        logic [7:0] rdata;  // read data
    } dlc_rsp_s;
    typedef struct packed {
        logic       load;  // one-cycle remote config load
        logic [5:0] cfg;   // remote config bits 5..0
    } dlc_fc_s;
    typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} dlc_clk_e;
endpackage : dlc_pkg

// ### hdl/dlc_phase_timer.sv
/*
 * phase timer: counts a programmed number of 50 ns units, then pulses done.
 * assumes: same clock as its user; width sampled at start.
 */
`timescale 1ns/10ps
module dlc_phase_timer #(
    parameter int UNIT = dlc_pkg::UNIT_CYC
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // control
    input  wire logic       start,
    input  wire logic [7:0] width,
    // status
    output logic            done
);
    // elaboration check: one unit must fit the 16-bit sub counter
    if (UNIT < 1 || UNIT > 65536) begin : g_unit_bad
        $error("dlc_phase_timer: UNIT must be 1 to 65536");
    end
    // all state in one struct
    typedef struct packed {
        logic [7:0]  units;  // remaining units
        logic [15:0] sub;    // cycles left in current unit
        logic        busy;
        logic        done;
    } dlc_tmr_s;
    dlc_tmr_s st_r, st_nxt;
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (start) begin
            // zero width still gives one unit, never a stuck phase
            st_nxt.units = (width == 8'h00) ? 8'h01 : width;
            st_nxt.sub   = 16'(UNIT - 1);
            st_nxt.busy  = 1'b1;
        end else if (st_r.busy) begin
            if (st_r.sub != 16'h0000) begin
                st_nxt.sub = st_r.sub - 16'h0001;
            end else if (st_r.units == 8'h01) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.units = st_r.units - 8'h01;
                st_nxt.sub   = 16'(UNIT - 1);
            end
        end
    end
    // register, frozen while ce low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end
    assign done = st_r.done;
endmodule : dlc_phase_timer

// ### verification/dlc_far_end.sv
/*
 * far-side model: remote serializer config loads and the pulled-up
 * local bus clock line.
 * assumes: one core clock; the bench calls send() from its main thread.
 */
`timescale 1ns/10ps
module dlc_far_end (
    // clock
    input  wire logic       core_clk,
    // local bus clock line
    input  wire logic       scl_oe,
    output logic            scl_in,
    // forward-channel config load
    output dlc_pkg::dlc_fc_s fc
);
    // ------------------------------------------------------------
    // bus clock line
    // ------------------------------------------------------------
    // pull-up: a released line reads high, a driven one low
    assign scl_in = !scl_oe;

    // ------------------------------------------------------------
    // remote config load
    // ------------------------------------------------------------
    initial fc = '0;
    // one-cycle load; dual link is never forced here
    task automatic send(input logic [5:0] cfg);
        @(posedge core_clk);
        fc <= '{1'b1, cfg};
        @(posedge core_clk);
        fc <= '0;
    endtask : send
endmodule : dlc_far_end

// ### verification/dlc_regs_chk.sv
/*
 * checker for dlc_regs: timing and decode relations seen at its ports.
 * assumes: bound to every dlc_regs; ce held high by the bench.
 */
`timescale 1ns/10ps
module dlc_regs_chk (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              ce,
    // register port and remote load
    input wire dlc_pkg::dlc_req_s req,
    input wire dlc_pkg::dlc_rsp_s rsp,
    input wire dlc_pkg::dlc_fc_s  fc,
    // lock, clock stretch, master clock
    input wire logic              rx_lock_mode,
    input wire logic              link_up,
    input wire logic              rx_lock,
    input wire logic              scl_oe,
    input wire logic              slave_data_set,
    input wire logic              slave_release,
    // decoded controls
    input wire logic              video_disabled,
    input wire logic              dual_link,
    input wire logic              ctrl_chan_en,
    input wire logic              audio_on_pins,
    input wire logic              audio_en,
    input wire logic              sync_bits_in_stream,
    input wire logic              surround_en
);
    // ------------------------------------------------------------
    // shadow state
    // ------------------------------------------------------------
    logic [7:0]  hw_r, lw_r;          // shadow widths
    logic [5:0]  cfg1_r, cfg2_r;      // load value, two stages late
    // lock inputs one cycle late: rx_lock and the decoded video flag
    // both trail the register by one cycle
    logic        frz_r, lock_r, mode_r, sl_pend_r;
    logic [11:0] hi_cnt_r, lo_cnt_r, sl_cnt_r, q_cnt_r;
    logic [11:0] hi_t, lo_t;          // phase lengths in cycles
    wire         w28 = req.wr && ce && req.addr == 8'h28;
    // zero width runs as one unit
    assign hi_t = 12'((hw_r == 8'h00) ? 8'h01 : hw_r) * 12'h00A;
    assign lo_t = 12'((lw_r == 8'h00) ? 8'h01 : lw_r) * 12'h00A;
    // saturating so long idle spans never wrap
    function automatic logic [11:0] inc(input logic [11:0] x);
        return (x == 12'hFFF) ? x : x + 12'h001;
    endfunction : inc
    // shadow registers and run counters
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {hw_r, lw_r} <= 16'h8384;
            {cfg1_r, cfg2_r, frz_r, lock_r, mode_r, sl_pend_r} <= '0;
            {hi_cnt_r, lo_cnt_r, sl_cnt_r, q_cnt_r} <= '0;
        end else begin
            if (req.wr && ce && req.addr == 8'h26) hw_r <= req.wdata;
            if (req.wr && ce && req.addr == 8'h27) lw_r <= req.wdata;
            if (w28) frz_r <= req.wdata[7];
            cfg1_r    <= fc.cfg;
            cfg2_r    <= cfg1_r;
            lock_r    <= link_up;
            mode_r    <= rx_lock_mode;
            sl_pend_r <= slave_data_set || (sl_pend_r && !slave_release);
            hi_cnt_r  <= scl_oe ? inc(hi_cnt_r) : 12'h000;
            lo_cnt_r  <= scl_oe ? 12'h000 : inc(lo_cnt_r);
            sl_cnt_r  <= slave_data_set ? 12'h000 : inc(sl_cnt_r);
            q_cnt_r   <= w28 ? 12'h000 : inc(q_cnt_r);
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_load;
        fc.load && !frz_r && !w28;
    endsequence
    sequence s_decoded;
        {video_disabled, dual_link, audio_on_pins, sync_bits_in_stream,
         audio_en, surround_en} == {cfg2_r[5:3], cfg2_r[1], !cfg2_r[2],
         cfg2_r[0] && !cfg2_r[2]};
    endsequence
    chk_read_answer: assert property (req.rd && ce |=> rsp.rvalid)
        else $error("read not answered");
    chk_low_readback: assert property (
        req.rd && !req.wr && req.addr == 8'h27 |=> rsp.rdata == lw_r)
        else $error("low width readback differs");
    chk_remote_load: assert property (s_load |-> ##2 s_decoded)
        else $error("remote load not decoded");
    chk_freeze_hold: assert property (frz_r && q_cnt_r >= 12'h004 |->
        $stable(video_disabled) && $stable(dual_link))
        else $error("frozen bits changed");
    chk_audio_pair: assert property (surround_en |-> audio_en)
        else $error("surround without audio");
    chk_lock_rule: assert property (
        rx_lock == (lock_r && (mode_r || !video_disabled)))
        else $error("lock level wrong");
    chk_ctrl_alive: assert property (!$past(rst, 3) |-> ctrl_chan_en)
        else $error("control channel off");
    chk_slave_hold: assert property (slave_release |-> sl_pend_r &&
        sl_cnt_r >= lo_t && sl_cnt_r <= lo_t + 12'h004)
        else $error("clock released at wrong time");
    chk_slave_bound: assert property (
        sl_pend_r |-> sl_cnt_r <= lo_t + 12'h005)
        else $error("clock held too long");
    chk_low_phase: assert property ($fell(scl_oe) |->
        hi_cnt_r >= lo_t && hi_cnt_r <= lo_t + 12'h003)
        else $error("low phase length wrong");
    chk_high_phase: assert property ($rose(scl_oe) |-> lo_cnt_r >= hi_t)
        else $error("high phase too short");
endmodule : dlc_regs_chk

bind dlc_regs dlc_regs_chk i_dlc_regs_chk (.core_clk, .rst, .ce, .req,
    .rsp, .fc, .rx_lock_mode, .link_up, .rx_lock, .scl_oe, .slave_data_set,
    .slave_release, .video_disabled, .dual_link, .ctrl_chan_en,
    .audio_on_pins, .audio_en, .sync_bits_in_stream, .surround_en);

// ### verification/dlc_regs_tb_top.sv
/*
 * self-checking bench for dlc_regs: register reads and writes, remote
 * loads, self-test tally, slave hold-off and master clock phases.
 * assumes: far-side model dlc_far_end and the bound checker.
 */
`timescale 1ns/10ps
module dlc_regs_tb_top;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1; // ce held on
    logic selftest_en = 1'b0, selftest_err = 1'b0, link_up = 1'b1;
    logic rx_lock_mode = 1'b0, master_go = 1'b0, master_stop = 1'b0;
    logic slave_data_set = 1'b0;
    dlc_pkg::dlc_req_s req = '0;
    dlc_pkg::dlc_rsp_s rsp;
    dlc_pkg::dlc_fc_s  fc;
    logic scl_in, scl_out, scl_oe, rx_lock, slave_release, ctrl_chan_en;
    logic video_disabled, dual_link, audio_on_pins, audio_en, surround_en;
    logic sync_bits_in_stream;
    logic [7:0] rst_val [5] = '{8'h00, 8'h83, 8'h84, 8'h00, 8'h00};
    int n_fail = 0, samples_checked = 0, cyc = 0, n;
    // 200 mhz core clock
    always #2.5 core_clk = ~core_clk;
    dlc_regs i_dlc_regs (.core_clk, .rst, .ce, .req, .rsp, .fc,
        .selftest_en, .selftest_err, .rx_lock_mode, .link_up, .rx_lock,
        .master_go, .master_stop, .scl_in, .scl_out, .scl_oe,
        .slave_data_set, .slave_release, .video_disabled, .dual_link,
        .ctrl_chan_en, .audio_on_pins, .audio_en, .sync_bits_in_stream,
        .surround_en);
    dlc_far_end i_dlc_far_end (.core_clk, .scl_oe, .scl_in, .fc);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        req <= '0;
    endtask : wr
    // answer lands one cycle after the strobe
    task automatic rd(input logic [7:0] a, e);
        @(posedge core_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        req <= '0;
        #1;
        chk("rvalid", 8'h01, {7'h00, rsp.rvalid});
        chk("rdata", e, rsp.rdata);
    endtask : rd
    // count samples while scl_oe equals lvl, bounded
    task automatic run(input logic lvl);
        n = 0;
        while (scl_oe === lvl && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : run
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // reset values, 29h unmapped reads zero
        for (int i = 0; i < 5; i++) rd(8'h25 + 8'(i), rst_val[i]);
        // three errors with self-test off, five with it on
        @(posedge core_clk);
        selftest_err <= 1'b1;
        repeat (3) @(posedge core_clk);
        selftest_en <= 1'b1;
        repeat (5) @(posedge core_clk);
        {selftest_en, selftest_err} <= 2'b00;
        rd(8'h25, 8'h05);
        wr(8'h25, 8'hAA);
        rd(8'h25, 8'h05);
        wr(8'h26, 8'h02);
        wr(8'h27, 8'h03);
        rd(8'h26, 8'h02);
        rd(8'h27, 8'h03);
        // slave hold-off of three units with the master idle
        @(posedge core_clk);
        slave_data_set <= 1'b1;
        @(posedge core_clk);
        slave_data_set <= 1'b0;
        #1;
        n = 1;
        while (slave_release !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("data setup", 8'h01, 8'(n >= 30 && n <= 34));
        // master clock: one low and one high phase, then stop
        @(posedge core_clk);
        master_go <= 1'b1;
        @(posedge core_clk);
        master_go <= 1'b0;
        #1;
        run(1'b0);
        run(1'b1);
        chk("low phase", 8'h01, 8'(n >= 30 && n <= 33));
        run(1'b0);
        chk("high phase", 8'h01, 8'(n >= 20 && n <= 26));
        @(posedge core_clk);
        master_stop <= 1'b1;
        repeat (100) @(posedge core_clk);
        #1;
        chk("idle clock", 8'h00, {7'h00, scl_oe});
        chk("clock drive", 8'h00, {7'h00, scl_out});
        // each remote bit alone, checked at pins and by readback
        for (int i = 0; i < 6; i++) begin
            i_dlc_far_end.send(6'(1 << i));
            repeat (3) @(posedge core_clk);
            #1;
            chk("decode", 8'(1 << i), {2'b00, video_disabled, dual_link,
                audio_on_pins, !audio_en, sync_bits_in_stream,
                surround_en});
            chk("lock", {7'h00, i != 5}, {7'h00, rx_lock});
            chk("control", 8'h01, {7'h00, ctrl_chan_en});
            rd(8'h28, 8'(1 << i));
        end
        // frozen register keeps the local value
        wr(8'h28, 8'h80);
        i_dlc_far_end.send(6'h3F);
        rd(8'h28, 8'h80);
        chk("frozen", 8'h00, {6'h00, video_disabled, dual_link});
        wr(8'h28, 8'h00);
        i_dlc_far_end.send(6'h30);
        rd(8'h28, 8'h30);
        // lock mode one ignores the video flag
        @(posedge core_clk);
        rx_lock_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("lock", 8'h01, {7'h00, rx_lock});
        close_out();
    end
endmodule : dlc_regs_tb_top
